/* File: inc/fbsel_pkg.sv */
// Functional notes
// [R1] Low half interfaces, high half protocols
// [R2] Control word flag positions fixed per interface
// [R3] Mask and enabled share control bit layout
// [R4] Availability read-only, preset 00010002h
// [R5] Availability bit set means interface present
// [R6] Control word read/write, preset 00010002h
// [R7] Only masked flags switch active state
// [R8] Disable mask read-only, resets to zero
// [R9] Enabled word read-only, preset 00010002h
// [R10] Enabled word follows control word outcome
// [R11] Status array: two entries, count 02h
// [R12] Unassigned bits read zero, ignore writes
package fbsel_pkg;

  // Word and address widths
  localparam int unsigned FBSEL_W      = 32;
  localparam int unsigned FBSEL_IDX_W  = 16;
  localparam int unsigned FBSEL_SUB_W  = 8;
  localparam int unsigned FBSEL_ADDR_W = FBSEL_IDX_W + FBSEL_SUB_W;

  // Halves of every selection word
  localparam int unsigned PHY_LSB   = 0;
  localparam int unsigned PHY_MSB   = 15;
  localparam int unsigned PROTO_LSB = 16;
  localparam int unsigned PROTO_MSB = 31;

  // Physical interface flag positions
  localparam int unsigned BIT_USB                     = 0;
  localparam int unsigned BIT_RS485                   = 1;
  localparam int unsigned BIT_RS232                   = 2;
  localparam int unsigned BIT_CAN                     = 3;
  localparam int unsigned BIT_WIRED_NETWORK_IF        = 4;
  localparam int unsigned BIT_INDUSTRIAL_NETWORK_IF   = 5;
  localparam int unsigned BIT_SPI                     = 6;

  // Protocol flag positions
  localparam int unsigned BIT_SERIAL_REGISTER_PROTOCOL = 16;
  localparam int unsigned BIT_TCP_REGISTER_PROTOCOL    = 17;
  localparam int unsigned BIT_INDUSTRIAL_IP_PROTOCOL   = 18;

  // Assigned flag positions; all others read zero
  localparam logic [FBSEL_W-1:0] FLAG_DEFINED_MASK = 32'h0007_007F;

  // Reset and preset values
  localparam logic [FBSEL_W-1:0]     AVAIL_RESET   = 32'h0001_0002;
  localparam logic [FBSEL_W-1:0]     CTRL_RESET    = 32'h0001_0002;
  localparam logic [FBSEL_W-1:0]     MASK_RESET    = 32'h0000_0000;
  localparam logic [FBSEL_W-1:0]     ENABLED_RESET = 32'h0001_0002;
  localparam logic [FBSEL_W-1:0]     WORD_ZERO     = 32'h0000_0000;
  localparam logic [FBSEL_SUB_W-1:0] STATUS_ENTRY_COUNT = 8'h02;

  // Object indices
  localparam logic [FBSEL_IDX_W-1:0] IDX_AVAIL  = 16'h2101;
  localparam logic [FBSEL_IDX_W-1:0] IDX_CTRL   = 16'h2102;
  localparam logic [FBSEL_IDX_W-1:0] IDX_STATUS = 16'h2103;
  localparam logic [FBSEL_IDX_W-1:0] IDX_DIAG   = 16'h2104;

  // Subindices
  localparam logic [FBSEL_SUB_W-1:0] SUB_VALUE   = 8'h00;
  localparam logic [FBSEL_SUB_W-1:0] SUB_COUNT   = 8'h00;
  localparam logic [FBSEL_SUB_W-1:0] SUB_MASK    = 8'h01;
  localparam logic [FBSEL_SUB_W-1:0] SUB_ENABLED = 8'h02;

  // Diagnostic word fields
  localparam int unsigned DIAG_IGNORED_BIT = 0;
  localparam int unsigned DIAG_UNMAPPED_BIT = 1;

  // Decoded access target, one-hot
  typedef enum logic [6:0] {
    TGT_NONE    = 7'b000_0001,
    TGT_AVAIL   = 7'b000_0010,
    TGT_CTRL    = 7'b000_0100,
    TGT_COUNT   = 7'b000_1000,
    TGT_MASK    = 7'b001_0000,
    TGT_ENABLED = 7'b010_0000,
    TGT_DIAG    = 7'b100_0000
  } fbsel_target_e;

endpackage

/* File: inc/fbsel_sel_if.sv */
`timescale 1ns/1ps
// Selection words passed between bank and switch
interface fbsel_sel_if;
  import fbsel_pkg::*;

  logic [FBSEL_W-1:0] ctrl;
  logic [FBSEL_W-1:0] mask;
  logic [FBSEL_W-1:0] avail;
  logic [FBSEL_W-1:0] enabled;
  logic [FBSEL_W-1:0] changed;

  // Bank side drives the request words
  modport bank (
    output ctrl,
    output mask,
    output avail,
    input  enabled,
    input  changed
  );

  // Switch side keeps the active state
  modport sw (
    input  ctrl,
    input  mask,
    input  avail,
    output enabled,
    output changed
  );
endinterface

/* File: verilog/fbsel_switch.sv */
`timescale 1ns/1ps
module fbsel_switch (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // Selection words
  fbsel_sel_if.sw   sel
);
  import fbsel_pkg::*;

  logic [FBSEL_W-1:0] enabled_reg;
  logic [FBSEL_W-1:0] enabled_next;
  logic [FBSEL_W-1:0] changed_reg;

  // Locked flags keep their state, masked flags follow control
  always_comb begin
    enabled_next = (enabled_reg & ~sel.mask) | (sel.ctrl & sel.mask); // [R7]
    enabled_next = enabled_next & sel.avail & FLAG_DEFINED_MASK; // [R12]
  end

  // Active state actually in effect
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      enabled_reg <= ENABLED_RESET; // [R9]
    end else begin
      enabled_reg <= enabled_next; // [R10]
    end
  end

  // Per-flag change pulse, aligned with the new state
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      changed_reg <= WORD_ZERO;
    end else begin
      changed_reg <= enabled_reg ^ enabled_next;
    end
  end

  assign sel.enabled = enabled_reg; // [R3]
  assign sel.changed = changed_reg;

endmodule // fbsel_switch

/* File: verilog/fbsel_bank.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module fbsel_bank #(
  parameter logic [fbsel_pkg::FBSEL_W-1:0] AVAIL_FLAGS = fbsel_pkg::AVAIL_RESET
) (
  // Clock and reset
  input  wire logic                              mclk_i,
  input  wire logic                              rst_i,
  // Register port
  input  wire logic [fbsel_pkg::FBSEL_ADDR_W-1:0] addr_i,
  input  wire logic [fbsel_pkg::FBSEL_W-1:0]      wdata_i,
  input  wire logic                              wr_i,
  input  wire logic                              rd_i,
  output logic      [fbsel_pkg::FBSEL_W-1:0]      rdata_o,
  output logic                                   rvalid_o,
  // Platform strap: flags that may be switched off
  input  wire logic [fbsel_pkg::FBSEL_W-1:0]      deactivatable_i,
  // Activation state
  output logic      [fbsel_pkg::FBSEL_W-1:0]      enabled_o,
  output logic      [fbsel_pkg::FBSEL_W-1:0]      locked_o,
  output logic                                   enable_change_o,
  // Per-interface enables
  output logic                                   usb_en_o,
  output logic                                   rs485_en_o,
  output logic                                   rs232_en_o,
  output logic                                   can_en_o,
  output logic                                   wired_network_if_en_o,
  output logic                                   industrial_network_if_en_o,
  output logic                                   spi_en_o,
  output logic                                   serial_register_protocol_en_o,
  output logic                                   tcp_register_protocol_en_o,
  output logic                                   industrial_ip_protocol_en_o,
  // Access diagnostics
  output logic                                   write_ignored_o
);
  import fbsel_pkg::*;

  // Address split
  logic [FBSEL_IDX_W-1:0] acc_idx;
  logic [FBSEL_SUB_W-1:0] acc_sub;
  fbsel_target_e           acc_tgt;

  // Register state
  logic [FBSEL_W-1:0]     avail_reg;
  logic [FBSEL_W-1:0]     ctrl_reg;
  logic [FBSEL_W-1:0]     ctrl_next;
  logic [FBSEL_W-1:0]     mask_reg;
  logic [FBSEL_W-1:0]     strap_meta_reg;
  logic [FBSEL_W-1:0]     strap_sync_reg;
  logic                   ignored_reg;
  logic                   unmapped_reg;
  logic                   ignored_set;
  logic                   unmapped_set;
  logic                   diag_clear;
  logic [FBSEL_W-1:0]     rdata_reg;
  logic [FBSEL_W-1:0]     rdata_next;
  logic                   rvalid_reg;
  logic                   change_reg;
  logic [FBSEL_W-1:0]     diag_word;

  // Selection words shared with the switch
  fbsel_sel_if sel ();

  assign acc_idx = addr_i[FBSEL_ADDR_W-1:FBSEL_SUB_W];
  assign acc_sub = addr_i[FBSEL_SUB_W-1:0];

  // Decode index and subindex into one target
  always_comb begin
    acc_tgt = TGT_NONE;
    if (acc_idx == IDX_AVAIL && acc_sub == SUB_VALUE) begin
      acc_tgt = TGT_AVAIL;
    end else if (acc_idx == IDX_CTRL && acc_sub == SUB_VALUE) begin
      acc_tgt = TGT_CTRL;
    end else if (acc_idx == IDX_STATUS) begin
      // Only two data entries behind the count
      if (acc_sub == SUB_COUNT) begin
        acc_tgt = TGT_COUNT; // [R11]
      end else if (acc_sub == SUB_MASK) begin
        acc_tgt = TGT_MASK; // [R11]
      end else if (acc_sub == SUB_ENABLED) begin
        acc_tgt = TGT_ENABLED; // [R11]
      end else begin
        acc_tgt = TGT_NONE;
      end
    end else if (acc_idx == IDX_DIAG && acc_sub == SUB_VALUE) begin
      acc_tgt = TGT_DIAG;
    end else begin
      acc_tgt = TGT_NONE;
    end
  end

  // Offered flags; held in a register so a read sees a stable word
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      avail_reg <= AVAIL_RESET; // [R4]
    end else begin
      avail_reg <= AVAIL_FLAGS & FLAG_DEFINED_MASK; // [R5] [R12]
    end
  end

  // Strap crossing; the first stage feeds only the second
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      strap_meta_reg <= WORD_ZERO;
      strap_sync_reg <= WORD_ZERO;
    end else begin
      strap_meta_reg <= deactivatable_i;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Switchable flags: only those offered and assigned
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mask_reg <= MASK_RESET; // [R8]
    end else begin
      mask_reg <= strap_sync_reg & avail_reg & FLAG_DEFINED_MASK; // [R8] [R12]
    end
  end

  // Control word write; undefined bits are dropped on the way in
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_i && acc_tgt == TGT_CTRL) begin
      ctrl_next = wdata_i & FLAG_DEFINED_MASK; // [R6] [R12]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET; // [R6]
    end else begin
      ctrl_reg <= ctrl_next; // [R6]
    end
  end

  // Words that the switch acts on
  assign sel.ctrl  = ctrl_reg; // [R2]
  assign sel.mask  = mask_reg; // [R3]
  assign sel.avail = avail_reg;

  // Switch keeps the active state; locked flags never move
  fbsel_switch u_switch (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .sel    (sel)
  );

  // A write is flagged ignored when it hits a read-only or unmapped word or
  // asks to move a flag that the mask does not free
  always_comb begin
    ignored_set = 1'b0;
    if (wr_i) begin
      case (acc_tgt)
        TGT_CTRL: begin
          ignored_set = |((wdata_i ^ sel.enabled) & ~mask_reg) ; // [R7]
        end
        TGT_AVAIL: begin
          ignored_set = 1'b1; // [R4]
        end
        TGT_COUNT, TGT_MASK, TGT_ENABLED: begin
          ignored_set = 1'b1; // [R11]
        end
        TGT_DIAG: begin
          ignored_set = 1'b1;
        end
        TGT_NONE: begin
          ignored_set = 1'b1;
        end
        default: begin
          ignored_set = 1'b1;
        end
      endcase
    end
  end

  // Unmapped read or write seen
  assign unmapped_set = (wr_i || rd_i) && (acc_tgt == TGT_NONE);

  // Reading the diagnostic word clears it
  assign diag_clear = rd_i && (acc_tgt == TGT_DIAG);

  // Sticky diagnostics; a new event in the clearing read wins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ignored_reg <= 1'b0;
    end else if (ignored_set) begin
      ignored_reg <= 1'b1;
    end else if (diag_clear) begin
      ignored_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      unmapped_reg <= 1'b0;
    end else if (unmapped_set) begin
      unmapped_reg <= 1'b1;
    end else if (diag_clear) begin
      unmapped_reg <= 1'b0;
    end
  end

  // Diagnostic word layout
  always_comb begin
    diag_word                    = WORD_ZERO;
    diag_word[DIAG_IGNORED_BIT]  = ignored_reg;
    diag_word[DIAG_UNMAPPED_BIT] = unmapped_reg;
  end

  // Read multiplexer; unmapped answers zero
  always_comb begin
    rdata_next = WORD_ZERO;
    if (rd_i) begin
      case (acc_tgt)
        TGT_AVAIL: begin
          rdata_next = avail_reg; // [R4] [R1]
        end
        TGT_CTRL: begin
          rdata_next = ctrl_reg; // [R6] [R2]
        end
        TGT_COUNT: begin
          rdata_next = {{(FBSEL_W-FBSEL_SUB_W){1'b0}}, STATUS_ENTRY_COUNT}; // [R11]
        end
        TGT_MASK: begin
          rdata_next = mask_reg; // [R8] [R3]
        end
        TGT_ENABLED: begin
          rdata_next = sel.enabled; // [R9] [R10]
        end
        TGT_DIAG: begin
          rdata_next = diag_word;
        end
        TGT_NONE: begin
          rdata_next = WORD_ZERO;
        end
        default: begin
          rdata_next = WORD_ZERO;
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_reg  <= WORD_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rd_i;
    end
  end

  // Any flag moved; pulse comes one cycle after the new state
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      change_reg <= 1'b0;
    end else begin
      change_reg <= |sel.changed;
    end
  end

  // Outputs
  assign rdata_o         = rdata_reg;
  assign rvalid_o        = rvalid_reg;
  assign enabled_o       = sel.enabled; // [R10]
  assign locked_o        = sel.enabled & ~mask_reg;
  assign enable_change_o = change_reg;
  assign write_ignored_o = ignored_reg;

  // Named enables at their fixed positions
  assign usb_en_o                      = sel.enabled[BIT_USB]; // [R2]
  assign rs485_en_o                    = sel.enabled[BIT_RS485]; // [R2]
  assign rs232_en_o                    = sel.enabled[BIT_RS232]; // [R2]
  assign can_en_o                      = sel.enabled[BIT_CAN]; // [R2]
  assign wired_network_if_en_o         = sel.enabled[BIT_WIRED_NETWORK_IF]; // [R2]
  assign industrial_network_if_en_o    = sel.enabled[BIT_INDUSTRIAL_NETWORK_IF]; // [R2]
  assign spi_en_o                      = sel.enabled[BIT_SPI]; // [R2]
  assign serial_register_protocol_en_o = sel.enabled[BIT_SERIAL_REGISTER_PROTOCOL]; // [R2]
  assign tcp_register_protocol_en_o    = sel.enabled[BIT_TCP_REGISTER_PROTOCOL]; // [R2]
  assign industrial_ip_protocol_en_o   = sel.enabled[BIT_INDUSTRIAL_IP_PROTOCOL]; // [R2]

endmodule // fbsel_bank

/* File: tb/fbsel_bank_props.sv */
`timescale 1ns/1ps
module fbsel_bank_props
  import fbsel_pkg::*;
#(
  parameter logic [fbsel_pkg::FBSEL_W-1:0] AVAIL_FLAGS = fbsel_pkg::AVAIL_RESET
) (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_i,
  // Register port
  input wire logic [23:0] addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        rvalid_o,
  // Activation state
  input wire logic [31:0] enabled_o,
  input wire logic [31:0] locked_o,
  input wire logic        enable_change_o,
  input wire logic        usb_en_o,
  input wire logic        rs485_en_o,
  input wire logic        rs232_en_o,
  input wire logic        can_en_o,
  input wire logic        wired_network_if_en_o,
  input wire logic        industrial_network_if_en_o,
  input wire logic        spi_en_o,
  input wire logic        serial_register_protocol_en_o,
  input wire logic        tcp_register_protocol_en_o,
  input wire logic        industrial_ip_protocol_en_o,
  input wire logic        write_ignored_o
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Read answers land one cycle late and only then
  read_answer_a: assert property (rd_i |=> rvalid_o) else $error("read not answered");
  idle_rdata_zero_a: assert property (!rvalid_o |-> rdata_o == 32'h0) else $error("rdata outside answer");
  // Availability shows its preset until the first edge after release
  avail_read_a: assert property (rd_i && addr_i == 24'h210100 && !$past(rst_i) |=>
    rdata_o == (AVAIL_FLAGS & 32'h0007_007F)) else $error("availability read wrong");
  count_read_a: assert property (rd_i && addr_i == 24'h210300 |=> rdata_o == 32'h0000_0002)
    else $error("entry count wrong");
  // Only offered, assigned flags can ever be active
  enabled_defined_a: assert property ((enabled_o & ~(AVAIL_FLAGS & 32'h0007_007F)) == 32'h0)
    else $error("enabled flag outside offered set");
  // History that spans a reset is not a change
  change_pulse_a: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    enable_change_o == ($past(enabled_o) != $past(enabled_o, 2))) else $error("change pulse mistimed");
  enable_map_a: assert property ({industrial_ip_protocol_en_o, tcp_register_protocol_en_o,
    serial_register_protocol_en_o, spi_en_o, industrial_network_if_en_o, wired_network_if_en_o,
    can_en_o, rs232_en_o, rs485_en_o, usb_en_o} == {enabled_o[18:16], enabled_o[6:0]}) else $error("enable map");
  ro_write_flag_a: assert property (wr_i && (addr_i[23:8] == 16'h2103 || addr_i == 24'h210100) |=>
    write_ignored_o) else $error("read-only write not flagged");
  // An active flag outside the mask stays active
  locked_kept_a: assert property (!$past(rst_i) |->
    (enabled_o & $past(locked_o) & AVAIL_FLAGS) == ($past(locked_o) & AVAIL_FLAGS)) else $error("locked flag moved");

  // Main scenarios reached
  cover property (rd_i && addr_i == 24'h210303);
  cover property (enable_change_o);
  cover property (write_ignored_o);
endmodule // fbsel_bank_props

bind fbsel_bank fbsel_bank_props #(.AVAIL_FLAGS(AVAIL_FLAGS)) u_props (.mclk_i, .rst_i, .addr_i, .wr_i,
  .rd_i, .rdata_o, .rvalid_o, .enabled_o, .locked_o, .enable_change_o, .usb_en_o, .rs485_en_o,
  .rs232_en_o, .can_en_o, .wired_network_if_en_o, .industrial_network_if_en_o, .spi_en_o,
  .serial_register_protocol_en_o, .tcp_register_protocol_en_o, .industrial_ip_protocol_en_o,
  .write_ignored_o);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import fbsel_pkg::*;
  // All flags offered so every position can be switched
  localparam logic [31:0] AVAIL_P = 32'h0007_007F;
  logic        mclk_i, rst_i, wr_i, rd_i;
  logic [23:0] addr_i;
  logic [31:0] wdata_i, deactivatable_i;
  logic [31:0] rdata_o, enabled_o, locked_o;
  logic        rvalid_o, enable_change_o, write_ignored_o;
  logic [9:0]  en;
  int          n_fail, samples_checked, cycles;
  int unsigned pos [10] = '{0, 1, 2, 3, 4, 5, 6, 16, 17, 18};

  fbsel_bank #(.AVAIL_FLAGS(AVAIL_P)) i_dut (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .rvalid_o, .deactivatable_i, .enabled_o, .locked_o, .enable_change_o,
    .usb_en_o(en[0]), .rs485_en_o(en[1]), .rs232_en_o(en[2]), .can_en_o(en[3]),
    .wired_network_if_en_o(en[4]), .industrial_network_if_en_o(en[5]), .spi_en_o(en[6]),
    .serial_register_protocol_en_o(en[7]), .tcp_register_protocol_en_o(en[8]),
    .industrial_ip_protocol_en_o(en[9]), .write_ignored_o);

  // 10 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe dropped on the taking edge, data sampled once settled
  task automatic reg_rd(input logic [23:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk({31'h0, rvalid_o}, 32'h1);
    chk(rdata_o, exp);
  endtask

  task automatic reg_wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // Strap changes on an edge, then passes two syncs and the mask register
  task automatic strap(input logic [31:0] s);
    @(posedge mclk_i);
    deactivatable_i <= s;
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, run needs about a hundred cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    rst_i = 1'b1;
    addr_i = 24'h00_0000;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    deactivatable_i = 32'h0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Presets after reset
    reg_rd(24'h210100, AVAIL_P);
    reg_rd(24'h210200, 32'h0001_0002);
    reg_rd(24'h210300, 32'h0000_0002);
    reg_rd(24'h210301, 32'h0000_0000);
    reg_rd(24'h210302, 32'h0001_0002);
    // Empty mask: stored but without effect
    reg_wr(24'h210200, 32'hFFFF_FFFF);
    reg_rd(24'h210200, 32'h0007_007F);
    chk(enabled_o, 32'h0001_0002);
    chk({31'h0, write_ignored_o}, 32'h1);
    reg_rd(24'h210400, 32'h0000_0001);
    chk({31'h0, write_ignored_o}, 32'h0);
    // Read-only objects refuse writes
    reg_wr(24'h210100, 32'h0);
    reg_wr(24'h210301, 32'hFFFF_FFFF);
    reg_rd(24'h210100, AVAIL_P);
    reg_rd(24'h210301, 32'h0);
    reg_rd(24'h210400, 32'h0000_0001);
    reg_rd(24'h210303, 32'h0);
    reg_rd(24'h210400, 32'h0000_0002);
    // Only one flag switchable
    strap(32'h0000_0002);
    reg_rd(24'h210301, 32'h0000_0002);
    reg_wr(24'h210200, 32'h0);
    repeat (2) @(posedge mclk_i);
    #1;
    chk(enabled_o, 32'h0001_0000);
    chk(locked_o, 32'h0001_0000);
    reg_rd(24'h210302, 32'h0001_0000);
    chk({31'h0, enable_change_o}, 32'h0);
    // Every flag switchable, walk each position alone
    strap(32'hFFFF_FFFF);
    reg_rd(24'h210301, 32'h0007_007F);
    for (int i = 0; i < 10; i++) begin
      reg_wr(24'h210200, 32'h1 << pos[i]);
      repeat (2) @(posedge mclk_i);
      #1;
      chk(enabled_o, 32'h1 << pos[i]);
      chk({22'h0, en}, 32'h1 << i);
      chk({31'h0, enable_change_o}, 32'h1);
    end
    reg_rd(24'h210302, 32'h0004_0000);
    // Second reset in mid-run brings the presets back
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    reg_rd(24'h210301, 32'h0000_0000);
    reg_rd(24'h210200, 32'h0001_0002);
    reg_rd(24'h210302, 32'h0001_0002);
    stop_test();
  end
endmodule // tb_top
